// ==== swm_pkg.sv ====
// constants shared by the sram write lane mask block
// Notes on behaviour
// R01 - 8-bit: both half masks low store all
// R02 - 8-bit: mask0 low only stores bits 3:0
// R03 - 8-bit: mask1 low only stores bits 7:4
// R04 - 18-bit: both masks low store all
// R05 - 18-bit: mask0 low only stores bits 8:0
// R06 - 18-bit: mask1 low only stores bits 17:9
// R07 - both masks high leave word unmodified
// R08 - 9-bit: single mask low stores all
// R09 - 9-bit: single mask high writes nothing
// R10 - write data registered on both clock rises
// R11 - read words launched on both clock rises
// R12 - power up deselected, read outputs undriven
// R13 - burst walks start address plus 0..3
// R14 - stopped clocks preferably both held high
// R15 - select after started operation is don't-care
// R16 - second consecutive read or write ignored
// R17 - each data word uses its own masks
// R18 - write words on next two cycles' rises
// R19 - port selects sampled on true rise only
// R20 - write address latched at write select rise
// R21 - first read word 2.5 cycles after address
// R22 - masks captured with their word, writes only
package swm_pkg;
  localparam int unsigned SYNC_STAGES = 3;     // pin synchroniser depth
  localparam int unsigned DEF_DATA_W  = 18;    // 8, 9 or 18
  localparam int unsigned DEF_ADDR_W  = 4;     // storage depth in address bits
  localparam int unsigned MASK_W      = 2;     // lane mask pins
  localparam int unsigned CLK_PERIOD_NS = 40;  // sys_clk period
  localparam logic [1:0]  BURST_FIRST = 2'h0;  // first word of a burst
  localparam logic [1:0]  BURST_LAST  = 2'h3;  // fourth word of a burst
  localparam logic [1:0]  WR_ARM_K    = 2'h1;  // true rises from write address to word 0
  localparam logic [1:0]  RD_ARM_K    = 2'h2;  // true rises from read address to arming
  localparam logic        OE_RST      = 1'b0;  // read outputs undriven after reset
  localparam logic [1:0]  MASK_ALL    = 2'h3;  // both lanes masked
  localparam logic [1:0]  MASK_NONE   = 2'h0;  // no lane masked
  localparam logic [1:0]  MASK_LO_ONLY = 2'h2; // only low lane written
  localparam logic [1:0]  MASK_HI_ONLY = 2'h1; // only high lane written
endpackage

// ==== swm_lane_merge.sv ====
// merges a new write word into the stored word lane by lane
`timescale 1ns/10ps
`default_nettype none
module swm_lane_merge #(
  parameter int unsigned DATA_W = swm_pkg::DEF_DATA_W
) (
  // words
  input  wire logic [DATA_W-1:0]         old_word,
  input  wire logic [DATA_W-1:0]         new_word,
  // active-low lane masks, bit 0 low lane
  input  wire logic [swm_pkg::MASK_W-1:0] mask_n,
  // merged result
  output logic      [DATA_W-1:0]         merged
);
  import swm_pkg::*;
  // the 9-bit width has one lane covering every bit, so mask bit 1 is ignored there
  localparam int unsigned LO_W = (DATA_W == 9) ? 9 : DATA_W / 2;

  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      if (i < LO_W) begin : g_lo
        assign merged[i] = mask_n[0] ? old_word[i] : new_word[i]; // R01 R02 R04 R05 R08 R09
      end else begin : g_hi
        assign merged[i] = mask_n[1] ? old_word[i] : new_word[i]; // R03 R06 R07
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== swm_top.sv ====
// sram core: pin sampling, write bursts with lane masks, read bursts
`timescale 1ns/10ps
`default_nettype none
module swm_top #(
  parameter int unsigned DATA_W = swm_pkg::DEF_DATA_W,
  parameter int unsigned ADDR_W = swm_pkg::DEF_ADDR_W
) (
  // system
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  // input clock pins from the controller
  input  wire logic                       k_clk,
  input  wire logic                       k_clk_n,
  // port selects, active low
  input  wire logic                       read_port_select_n,
  input  wire logic                       write_port_select_n,
  // lane write masks, active low (half_lane_write_mask in the 8-bit width)
  input  wire logic [swm_pkg::MASK_W-1:0] lane_write_mask_n,
  // shared address and write data
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic [DATA_W-1:0]          wdata,
  // read data and its output enable
  output logic      [DATA_W-1:0]          rdata,
  output logic                            rdata_oe
);
  import swm_pkg::*;

  localparam int unsigned DEPTH = 1 << ADDR_W;             // words of storage
  localparam int unsigned PW    = 4 + MASK_W + ADDR_W + DATA_W; // pin vector width

  // whole module state
  typedef struct packed {
    logic [SYNC_STAGES-1:0][PW-1:0] sync;     // pin synchroniser
    logic                           k_stab;   // agreed true clock level
    logic                           kn_stab;  // agreed complement clock level
    logic                           rd_last;  // read started at previous true rise
    logic                           wr_last;  // write started at previous true rise
    logic                           wr_pend;  // write address waiting for word 0
    logic [ADDR_W-1:0]              wr_paddr; // latched write address
    logic                           wr_act;   // write burst taking words
    logic [ADDR_W-1:0]              wr_addr;  // active write start address
    logic [1:0]                     wr_idx;   // next write word
    logic                           rd_pend;  // read address waiting for latency
    logic [1:0]                     rd_kcnt;  // true rises since read address
    logic [ADDR_W-1:0]              rd_paddr; // latched read address
    logic                           rd_act;   // read burst launching words
    logic [ADDR_W-1:0]              rd_addr;  // active read start address
    logic [1:0]                     rd_idx;   // next read word
    logic [DATA_W-1:0]              q;        // read data flop
    logic                           oe;       // read enable flop
    logic [DEPTH-1:0][DATA_W-1:0]   mem;      // storage array
  } swm_state_t;

  swm_state_t st;       // registered state
  swm_state_t next_st;  // next state

  // fields of the agreed (third stage) pin sample
  logic               p_k;      // true clock
  logic               p_kn;     // complement clock
  logic               p_rsel_n; // read select
  logic               p_wsel_n; // write select
  logic [MASK_W-1:0]  p_mask_n; // lane masks
  logic [ADDR_W-1:0]  p_addr;   // address
  logic [DATA_W-1:0]  p_wdata;  // write data
  logic               k_agree;  // second and third stages agree on the true clock
  logic               kn_agree; // same for the complement clock
  logic               k_rise;   // accepted true clock rise
  logic               kn_rise;  // accepted complement clock rise
  logic               any_rise; // a data edge of either clock
  logic               rd_ok;    // read start accepted
  logic               wr_ok;    // write start accepted
  logic               wr_fire;  // a write word lands this cycle
  logic [ADDR_W-1:0]  wr_waddr; // its location
  logic [MASK_W-1:0]  wr_mask;  // its masks
  logic [DATA_W-1:0]  wr_old;   // stored word at that location
  logic [DATA_W-1:0]  wr_new;   // merged word to store

  // burst location: start plus word index, wrapping within the array
  function automatic logic [ADDR_W-1:0] burst_loc(input logic [ADDR_W-1:0] base,
                                                  input logic [1:0] idx);
    burst_loc = base + ADDR_W'(idx); // R13
  endfunction

  // pin fields unpacked from the last synchroniser stage
  assign {p_k, p_kn, p_rsel_n, p_wsel_n, p_mask_n, p_addr, p_wdata} = st.sync[2];

  // edges count only once the second and third stages agree, so a one-flop glitch
  // on a clock pin is never taken as a rise
  assign k_agree  = (st.sync[1][PW-1] == p_k);
  assign kn_agree = (st.sync[1][PW-2] == p_kn);
  assign k_rise   = k_agree & p_k & ~st.k_stab;
  assign kn_rise  = kn_agree & p_kn & ~st.kn_stab;
  assign any_rise = k_rise | kn_rise;

  // selects are looked at only on true rises; a repeat of last rise's start is dropped,
  // and with both selected the read wins unless a read started last rise
  assign rd_ok = k_rise & ~p_rsel_n & ~st.rd_last;          // R15 R16 R19
  assign wr_ok = k_rise & ~p_wsel_n & ~st.wr_last & ~rd_ok; // R15 R16 R19 R20

  // a write word lands on the arming true rise or on any edge of an active burst
  assign wr_fire  = (k_rise & st.wr_pend) | (any_rise & st.wr_act); // R10 R18 R22
  assign wr_waddr = st.wr_act ? burst_loc(st.wr_addr, st.wr_idx)
                              : burst_loc(st.wr_paddr, BURST_FIRST);
  assign wr_mask  = p_mask_n;   // sampled with this very word R17 R22
  assign wr_old   = st.mem[wr_waddr];

  // lane masking
  swm_lane_merge #(
    .DATA_W (DATA_W)
  ) u_merge (
    .old_word (wr_old),
    .new_word (p_wdata),
    .mask_n   (wr_mask),
    .merged   (wr_new)
  );

  // next state
  always_comb begin
    next_st = st;
    // pins shift through three stages; each stage reads the one before
    next_st.sync[0] = {k_clk, k_clk_n, read_port_select_n, write_port_select_n,
                       lane_write_mask_n, addr, wdata};
    next_st.sync[1] = st.sync[0];
    next_st.sync[2] = st.sync[1];
    if (k_agree) begin
      next_st.k_stab = p_k;
    end
    if (kn_agree) begin
      next_st.kn_stab = p_kn;
    end

    // write data path: store the merged word
    if (wr_fire) begin
      next_st.mem[wr_waddr] = wr_new; // R01 R02 R03 R04 R05 R06 R07 R08 R09 R10
    end
    if (any_rise && st.wr_act) begin
      next_st.wr_idx = st.wr_idx + 2'h1;
      if (st.wr_idx == BURST_LAST) begin
        next_st.wr_act = 1'b0;
      end
    end
    if (k_rise && st.wr_pend) begin
      // word 0 landed above; words 1..3 follow on the next three edges
      next_st.wr_pend = 1'b0;
      next_st.wr_act  = 1'b1;
      next_st.wr_addr = st.wr_paddr;
      next_st.wr_idx  = BURST_FIRST + WR_ARM_K;
    end

    // read launch: one word per edge of either clock, undriven between bursts;
    // the word comes from storage as it stands before this edge, so a write landing
    // on the same edge is not forwarded and a user must keep such bursts apart
    if (any_rise) begin
      if (st.rd_act) begin
        next_st.q      = st.mem[burst_loc(st.rd_addr, st.rd_idx)]; // R11 R13
        next_st.oe     = 1'b1;
        next_st.rd_idx = st.rd_idx + 2'h1;
        if (st.rd_idx == BURST_LAST) begin
          next_st.rd_act = 1'b0;
        end
      end else begin
        next_st.oe = 1'b0; // R12
      end
    end
    // second true rise after the address arms the burst; first word on the next edge
    if (k_rise && st.rd_pend) begin
      next_st.rd_kcnt = st.rd_kcnt + 2'h1;
      if (st.rd_kcnt + 2'h1 == RD_ARM_K) begin
        next_st.rd_pend = 1'b0; // R21
        next_st.rd_act  = 1'b1;
        next_st.rd_addr = st.rd_paddr;
        next_st.rd_idx  = BURST_FIRST;
      end
    end

    // new starts, taken after the older request has been moved on
    if (k_rise) begin
      next_st.rd_last = rd_ok;
      next_st.wr_last = wr_ok;
    end
    if (rd_ok) begin
      next_st.rd_pend  = 1'b1;
      next_st.rd_kcnt  = 2'h0;
      next_st.rd_paddr = p_addr;
    end
    if (wr_ok) begin
      next_st.wr_pend  = 1'b1; // R20
      next_st.wr_paddr = p_addr;
    end
  end

  // state register; powers up deselected with outputs off
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st    <= '0;
      st.oe <= OE_RST; // R12
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata    = st.q;
  assign rdata_oe = st.oe;

  // checks: every property runs on sys_clk and is held off through reset; a stored word
  // is judged one cycle after the edge that stores it, against the word it replaced
  // lanes are compared through bit masks, since a part-select of the high lane would run
  // backwards in the 9-bit width, where the low lane already covers every bit
  // the masks cover the 9-bit width as well, so no width is left out of the lane checks
  localparam int unsigned       LO_W    = (DATA_W == 9) ? 9 : DATA_W / 2;  // low lane width
  localparam logic [DATA_W-1:0] LO_MASK = DATA_W'((64'h1 << LO_W) - 64'h1); // low lane bits
  localparam logic [DATA_W-1:0] HI_MASK = ~LO_MASK;                          // high lane bits

  // an unmasked word replaces every bit
  full_store_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R01 R04 R08
    wr_fire && wr_mask == MASK_NONE |=> st.mem[$past(wr_waddr)] == $past(p_wdata))
    else $error("unmasked write word not stored");

  // a fully masked word leaves the location as it was
  no_store_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R07 R09
    wr_fire && wr_mask == MASK_ALL |=> st.mem[$past(wr_waddr)] == $past(wr_old))
    else $error("fully masked write changed the word");

  // low lane only; in the 9-bit width this is a full store
  low_lane_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R02 R05
    wr_fire && wr_mask == MASK_LO_ONLY |=>
      (st.mem[$past(wr_waddr)] & LO_MASK) == ($past(p_wdata) & LO_MASK) &&
      (st.mem[$past(wr_waddr)] & HI_MASK) == ($past(wr_old) & HI_MASK))
    else $error("low lane write wrong");

  // high lane only; in the 9-bit width nothing is stored
  high_lane_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R03 R06
    wr_fire && wr_mask == MASK_HI_ONLY |=>
      (st.mem[$past(wr_waddr)] & LO_MASK) == ($past(wr_old) & LO_MASK) &&
      (st.mem[$past(wr_waddr)] & HI_MASK) == ($past(p_wdata) & HI_MASK))
    else $error("high lane write wrong");

  // storage moves only on a data edge of a write burst
  write_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R22
    !wr_fire |=> $stable(st.mem))
    else $error("storage changed outside a write word");

  // off a true rise no start is latched and the last-start flags hold
  select_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
    !k_rise |=> $stable(st.rd_paddr) && $stable(st.wr_paddr) &&
                $stable(st.rd_last) && $stable(st.wr_last))
    else $error("start taken off a true rise");

  // a write request on the rise after a write start is dropped
  no_repeat_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
    k_rise && st.wr_last |=> $stable(st.wr_paddr) && !st.wr_last)
    else $error("back to back write accepted");

  // a read request on the rise after a read start is dropped
  read_repeat_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R15 R16
    k_rise && st.rd_last |=> $stable(st.rd_paddr) && !st.rd_last)
    else $error("back to back read accepted");

  // the write address becomes the burst start on the next true rise
  write_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R18 R20
    k_rise && st.wr_pend |=>
      st.wr_act && st.wr_idx == 2'h1 && st.wr_addr == $past(st.wr_paddr))
    else $error("write burst not armed");

  // the second true rise after a read address arms its burst at word 0
  read_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R21
    k_rise && st.rd_pend && st.rd_kcnt == 2'h1 |=>
      st.rd_act && st.rd_idx == BURST_FIRST && st.rd_addr == $past(st.rd_paddr))
    else $error("read burst not armed on time");

  // each launch edge drives the addressed burst word
  launch_word_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R11 R13
    any_rise && st.rd_act |=>
      rdata_oe && rdata == $past(st.mem[st.rd_addr + ADDR_W'(st.rd_idx)]))
    else $error("read word launched wrong");

  // the read enable moves only on a clock pin rise
  launch_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
    $changed(rdata_oe) |-> $past(any_rise))
    else $error("read enable moved off an edge");

  // no burst in flight: the outputs go undriven at the next edge
  idle_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
    !st.rd_act && !st.rd_pend && any_rise |=> !rdata_oe)
    else $error("read outputs driven while idle");

  // write words walk the start address upwards, wrapping in the array
  word_walk_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
    any_rise && st.wr_act |-> wr_waddr == st.wr_addr + ADDR_W'(st.wr_idx))
    else $error("burst address walk wrong");

  // main scenarios: write start, read burst, both selects, a lane mask and a
  // dropped back-to-back write
  write_start_c: cover property (@(posedge sys_clk) disable iff (!nrst) wr_ok);
  read_burst_c:  cover property (@(posedge sys_clk) disable iff (!nrst) $rose(rdata_oe));
  both_sel_c:    cover property (@(posedge sys_clk) disable iff (!nrst)
    k_rise && !p_rsel_n && !p_wsel_n);
  lane_mask_c:   cover property (@(posedge sys_clk) disable iff (!nrst)
    wr_fire && wr_mask == MASK_HI_ONLY);
  dup_write_c:   cover property (@(posedge sys_clk) disable iff (!nrst)
    k_rise && st.wr_last && !p_wsel_n);
endmodule
`default_nettype wire

// ==== swm_ctrl_model.sv ====
// controller model driving the sram pins: clock pins, selects, masks, address, data
`timescale 1ns/10ps
`default_nettype none
module swm_ctrl_model (
  // pacing clock
  input  wire logic   sys_clk,
  // input clock pins
  output logic        k_clk,
  output logic        k_clk_n,
  // selects, masks, address and write data
  output logic        read_port_select_n,
  output logic        write_port_select_n,
  output logic [1:0]  lane_write_mask_n,
  output logic [3:0]  addr,
  output logic [17:0] wdata
);
  // clock pins low through reset, otherwise a high level reads as a rise
  initial begin
    k_clk = 1'b0;
    k_clk_n = 1'b0;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    lane_write_mask_n = 2'h0;
    addr = 4'h0;
    wdata = 18'h00000;
  end

  // one clock pin rise: inputs set 5 cycles before, held 6 after, since
  // the pins cross a 3-flop synchroniser
  task automatic pin_rise(input bit tru, input logic rs_n, input logic ws_n,
                          input logic [3:0] a, input logic [17:0] d, input logic [1:0] m);
    @(posedge sys_clk);
    #1;
    read_port_select_n = rs_n;
    write_port_select_n = ws_n;
    addr = a;
    wdata = d;
    lane_write_mask_n = m;
    if (tru) k_clk = 1'b0;
    else k_clk_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    if (tru) k_clk = 1'b1;
    else k_clk_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    // released pins show no stale value: data and address inverted
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = ~a;
    wdata = ~d;
    lane_write_mask_n = ~m;
    // the clock pin is left high while idle for a quick restart
  endtask
endmodule
`default_nettype wire

// ==== sram_write_lane_mask_bench.sv ====
// self-checking bench: three widths share one controller model
`timescale 1ns/10ps
`default_nettype none
module sram_write_lane_mask_bench;
  import swm_pkg::*;
  logic sys_clk, nrst, k_clk, k_clk_n, rps_n, wps_n;
  logic [1:0]  mask_n;
  logic [3:0]  addr;
  logic [17:0] wdata, rd18;
  logic [7:0]  rd8;
  logic [8:0]  rd9;
  logic        oe18, oe8, oe9;
  int          fails, num_checks, cycles;
  logic [17:0] e18[16]; // expected storage per width
  logic [7:0]  e8[16];
  logic [8:0]  e9[16];

  swm_ctrl_model ctrl (.sys_clk(sys_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wdata(wdata));
  swm_top #(.DATA_W(18)) uut (.sys_clk(sys_clk), .nrst(nrst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wdata(wdata), .rdata(rd18), .rdata_oe(oe18));
  swm_top #(.DATA_W(8)) uut_b8 (.sys_clk(sys_clk), .nrst(nrst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wdata(wdata[7:0]), .rdata(rd8), .rdata_oe(oe8));
  swm_top #(.DATA_W(9)) uut_b9 (.sys_clk(sys_clk), .nrst(nrst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wdata(wdata[8:0]), .rdata(rd9), .rdata_oe(oe9));

  initial sys_clk = 1'b0;
  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  // hang guard: the whole run needs about 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // lane merge worked out bit by bit; lo is the width of the low lane
  function automatic logic [17:0] mrg(logic [17:0] o, logic [17:0] n, logic [1:0] m, int lo);
    logic [17:0] r;
    r = o;
    for (int i = 0; i < 18; i++) if (!m[i < lo ? 0 : 1]) r[i] = n[i];
    return r;
  endfunction

  // write burst; with dup a second write is requested on the next true rise
  task automatic wr_burst(input logic [3:0] a, input logic [3:0][17:0] d,
                          input logic [3:0][1:0] m, input bit dup, input logic [3:0] b);
    logic [3:0] idx;
    ctrl.pin_rise(1, 1, 0, a, ~d[0], MASK_NONE);
    ctrl.pin_rise(0, 1, 1, a, ~d[1], MASK_NONE); // masks here lie outside the burst
    for (int i = 0; i < 4; i++) begin
      ctrl.pin_rise(i % 2 == 0, 1, (i == 0 && dup) ? 1'b0 : 1'b1, (i == 0) ? b : a, d[i], m[i]);
      idx = a + 4'(i); // wraps modulo 16
      e18[idx] = mrg(e18[idx], d[i], m[i], 9);
      e9[idx] = 9'(mrg(18'(e9[idx]), d[i], m[i], 9));
      e8[idx] = 8'(mrg(18'(e8[idx]), d[i], m[i], 4));
    end
  endtask

  // read burst; words expected on the 5th to 8th rise after the address
  task automatic rd_burst(input logic [3:0] a, input bit dup, input logic [3:0] b);
    logic [3:0] idx;
    ctrl.pin_rise(1, 0, 1, a, 18'h15555, MASK_NONE);
    for (int j = 1; j < 10; j++) begin
      ctrl.pin_rise(j % 2 == 0, (j == 2 && dup) ? 1'b0 : 1'b1, 1, (j == 2) ? b : a,
                    18'h2AAAA, MASK_NONE);
      idx = a + 4'(j - 5);
      if (j < 5) check("oe before data", 18'(oe18), 18'h00000);
      else if (j < 9) begin
        check("rdata 18", rd18, e18[idx]);
        check("rdata 9", 18'(rd9), 18'(e9[idx]));
        check("rdata 8", 18'(rd8), 18'(e8[idx]));
        check("oe in burst", 18'({oe18, oe9, oe8}), 18'h00007);
      end else check("oe after burst", 18'(oe18), 18'h00000);
    end
  endtask

  // reset leaves outputs undriven and read data cleared
  task automatic t_reset();
    check("oe at reset", 18'({oe18, oe9, oe8}), 18'h00000);
    check("rdata at reset", rd18, 18'h00000);
  endtask

  // fill a wrapping burst, then rewrite it with a different mask per word
  task automatic t_masks();
    wr_burst(4'hE, {4{18'h3FFFF}}, {4{MASK_NONE}}, 0, 4'hE);
    rd_burst(4'hE, 0, 4'hE);
    wr_burst(4'hE, {18'h01234, 18'h0A50F, 18'h15A3C, 18'h2C0C3},
             {MASK_ALL, MASK_HI_ONLY, MASK_LO_ONLY, MASK_NONE}, 0, 4'hE);
    rd_burst(4'hE, 0, 4'hE);
  endtask

  // second read and write on consecutive true rises must be dropped
  task automatic t_dup();
    wr_burst(4'h3, {18'h0F0F0, 18'h33333, 18'h2D2D2, 18'h1E1E1}, {4{MASK_NONE}}, 1, 4'h8);
    rd_burst(4'h3, 1, 4'h8);
    rd_burst(4'h8, 0, 4'h8); // untouched words still read as cleared
  endtask

  // both selects from idle: the read wins, the write takes the next true rise, and
  // the two bursts then run side by side on disjoint words
  task automatic t_both();
    logic [17:0] d;
    logic [3:0]  idx;
    ctrl.pin_rise(1, 0, 0, 4'h5, 18'h00000, MASK_NONE);
    ctrl.pin_rise(0, 0, 0, 4'hA, 18'h00000, MASK_NONE); // selects ignored off true rises
    ctrl.pin_rise(1, 0, 0, 4'h9, 18'h00000, MASK_NONE);
    for (int j = 0; j < 7; j++) begin
      d = 18'h0C3A5 ^ 18'(j);
      ctrl.pin_rise(j % 2 == 1, 1, 1, 4'h9, d, MASK_NONE);
      idx = 4'h9 + 4'(j - 1);
      if (j >= 1 && j <= 4) begin
        e18[idx] = d;
        e9[idx] = d[8:0];
        e8[idx] = d[7:0];
      end
      idx = 4'h5 + 4'(j - 2);
      if (j >= 2 && j <= 5) begin
        check("both rdata 18", rd18, e18[idx]);
        check("both rdata 9", 18'(rd9), 18'(e9[idx]));
        check("both rdata 8", 18'(rd8), 18'(e8[idx]));
      end else check("both oe idle", 18'(oe18), 18'h00000);
    end
    rd_burst(4'h9, 0, 4'h9);
  endtask

  initial begin
    nrst = 1'b0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    for (int i = 0; i < 16; i++) begin
      e18[i] = 18'h00000;
      e9[i] = 9'h000;
      e8[i] = 8'h00;
    end
    repeat (10) @(posedge sys_clk);
    #1;
    t_reset();
    nrst = 1'b1;
    t_masks();
    t_dup();
    t_both();
    stop_test();
  end
endmodule
`default_nettype wire
